// >>> hdl/pin_mux_top.sv
// Shared pin function selector: routes each package pin to its default
// or secondary function unit under software control, plus the clock rate.
// Assumes core-side signals are synchronous to pclk; pad inputs likewise.
`timescale 1ns/1ps
module pin_mux_top
    import pin_mux_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Core-side sources
    input  wire logic        port_c2_out,
    input  wire logic        port_c2_oe,
    input  wire logic        memory_write_strobe_n,
    input  wire logic        memory_read_strobe_n,
    input  wire logic        memory_request_n,
    input  wire logic        io_select_one_n,
    input  wire logic        daisy_chain_enable_out,
    input  wire logic        refresh_cycle_n,
    input  wire logic        host_dma_request_1,
    input  wire logic        bus_grant_out_n,
    input  wire logic        host_drive_disable_n,
    input  wire logic        serial0_transmit_out,
    // Core-side results
    output logic             port_c_line_2,
    output logic             host_addr_line_7,
    output logic             daisy_chain_enable_in,
    output logic             host_addr_line_3,
    output logic             host_addr_line_4,
    output logic             bus_stall_in_n,
    output logic             host_dma_ack_1_n,
    output logic             bus_hold_request_in_n,
    output logic             interrupt_in_1_n,
    output logic             interrupt_in_2_n,
    output logic             port_c_line_6,
    output logic             port_c_line_7,
    output logic             com_decode_enable,
    output logic             sys_clk_tick,
    // Package pins
    input  wire logic        pin_c2_in,
    output logic             pin_c2_out,
    output logic             pin_c2_oe,
    output logic             pin_mem_ctl_out,
    output logic             pin_sel1_out,
    input  wire logic        pin_a7_in,
    input  wire logic        pin_a3_in,
    output logic             pin_a3_out,
    output logic             pin_a3_oe,
    input  wire logic        pin_a4_in,
    output logic             pin_dma_req_out,
    output logic             pin_dma_req_oe,
    input  wire logic        pin_dma_ack_in,
    output logic             pin_drv_dis_out,
    input  wire logic        pin_irq1_in,
    input  wire logic        pin_irq2_in,
    output logic             pin_clk_out
);

    pin_ctrl_if ctrl ();

    logic tick;
    logic phi;
    logic out_live_r;

    // Pin output next values
    logic c2_out_nxt, c2_oe_nxt, mem_ctl_nxt, sel1_nxt;
    logic a3_out_nxt, a3_oe_nxt, dma_req_nxt, dma_req_oe_nxt, drv_dis_nxt;

    // Core-side next values
    logic a7_nxt, daisy_in_nxt, a3_nxt, a4_nxt, stall_nxt;
    logic dma_ack_nxt, hold_req_nxt, irq1_nxt, irq2_nxt, pc6_nxt, pc7_nxt;

    // Register slave
    pin_mux_regs u_regs (
        .pclk    (pclk),
        .presetn (presetn),
        .paddr   (paddr),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .pwdata  (pwdata),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr),
        .ctrl    (ctrl.regs)
    );

    // Clock rate generator
    sys_clk_gen u_clk (
        .pclk    (pclk),
        .presetn (presetn),
        .div1    (ctrl.clk_div1),
        .mult    (ctrl.clk_mult),
        .tick_r  (tick),
        .phi_r   (phi)
    );

    // Status word: selected pin levels and the clock phase, for software
    assign ctrl.status = {phi, port_c_line_7, port_c_line_6, host_addr_line_4,
                          host_addr_line_3, host_addr_line_7, port_c_line_2,
                          bus_hold_request_in_n};

    // Output-enable pins stay floating in reset; all but port-mode pin_c2_oe also for one cycle after it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_live_r <= 1'b0;
        end else begin
            out_live_r <= 1'b1;
        end
    end

    // write strobe on port C line
    assign c2_out_nxt  = ctrl.mem_strobe_sel ? memory_write_strobe_n : port_c2_out;
    assign c2_oe_nxt   = ctrl.mem_strobe_sel ? out_live_r : port_c2_oe;
    assign mem_ctl_nxt = ctrl.mem_strobe_sel ? memory_read_strobe_n : memory_request_n;

    assign sel1_nxt = ctrl.daisy_out_sel ? daisy_chain_enable_out : io_select_one_n;

    assign a3_out_nxt = refresh_cycle_n;
    assign a3_oe_nxt  = ~ctrl.com_pin_sel & out_live_r;

    assign dma_req_nxt    = ctrl.bus_swap_sel ? bus_grant_out_n : host_dma_request_1;
    assign dma_req_oe_nxt = out_live_r;

    assign drv_dis_nxt = ctrl.serial_tx_sel ? serial0_transmit_out : host_drive_disable_n;

    // inputs split; unused daisy and stall inputs read high
    assign a7_nxt       = ctrl.com_pin_sel ? pin_a7_in : 1'b0;
    assign daisy_in_nxt = ctrl.com_pin_sel ? 1'b1 : pin_a7_in;
    assign a3_nxt       = ctrl.com_pin_sel ? pin_a3_in : 1'b0;
    assign a4_nxt       = ctrl.com_pin_sel ? pin_a4_in : 1'b0;
    assign stall_nxt    = ctrl.com_pin_sel ? 1'b1 : pin_a4_in;

    assign dma_ack_nxt  = ctrl.bus_swap_sel ? 1'b1 : pin_dma_ack_in;
    assign hold_req_nxt = ctrl.bus_swap_sel ? pin_dma_ack_in : 1'b1;

    assign irq1_nxt = ctrl.int_as_port_sel ? 1'b1 : pin_irq1_in;
    assign irq2_nxt = ctrl.int_as_port_sel ? 1'b1 : pin_irq2_in;
    assign pc6_nxt  = ctrl.int_as_port_sel ? pin_irq1_in : 1'b0;
    assign pc7_nxt  = ctrl.int_as_port_sel ? pin_irq2_in : 1'b0;

    // Pad-side registers; strobes reset inactive high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_c2_out      <= 1'b1;
            pin_c2_oe       <= 1'b0;
            pin_mem_ctl_out <= 1'b1;
            pin_sel1_out    <= 1'b1;
            pin_a3_out      <= 1'b1;
            pin_a3_oe       <= 1'b0;
            pin_dma_req_out <= 1'b0;
            pin_dma_req_oe  <= 1'b0;
            pin_drv_dis_out <= 1'b1;
            pin_clk_out     <= 1'b0;
        end else begin
            pin_c2_out      <= c2_out_nxt;
            pin_c2_oe       <= c2_oe_nxt;
            pin_mem_ctl_out <= mem_ctl_nxt;
            pin_sel1_out    <= sel1_nxt;
            pin_a3_out      <= a3_out_nxt;
            pin_a3_oe       <= a3_oe_nxt;
            pin_dma_req_out <= dma_req_nxt;
            pin_dma_req_oe  <= dma_req_oe_nxt;
            pin_drv_dis_out <= drv_dis_nxt;
            pin_clk_out     <= phi;
        end
    end

    // Core-side registers; active-low inputs reset to their idle level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_c_line_2         <= 1'b0;
            host_addr_line_7      <= 1'b0;
            daisy_chain_enable_in <= 1'b1;
            host_addr_line_3      <= 1'b0;
            host_addr_line_4      <= 1'b0;
            bus_stall_in_n        <= 1'b1;
            host_dma_ack_1_n      <= 1'b1;
            bus_hold_request_in_n <= 1'b1;
            interrupt_in_1_n      <= 1'b1;
            interrupt_in_2_n      <= 1'b1;
            port_c_line_6         <= 1'b0;
            port_c_line_7         <= 1'b0;
        end else begin
            port_c_line_2         <= pin_c2_in;
            host_addr_line_7      <= a7_nxt;
            daisy_chain_enable_in <= daisy_in_nxt;
            host_addr_line_3      <= a3_nxt;
            host_addr_line_4      <= a4_nxt;
            bus_stall_in_n        <= stall_nxt;
            host_dma_ack_1_n      <= dma_ack_nxt;
            bus_hold_request_in_n <= hold_req_nxt;
            interrupt_in_1_n      <= irq1_nxt;
            interrupt_in_2_n      <= irq2_nxt;
            port_c_line_6         <= pc6_nxt;
            port_c_line_7         <= pc7_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            com_decode_enable <= 1'b0;
            sys_clk_tick      <= 1'b0;
        end else begin
            com_decode_enable <= ctrl.com_decode_en;
            sys_clk_tick      <= tick;
        end
    end

endmodule

// >>> hdl/pin_mux_pkg.sv
// Package for the shared-pin function selector.
// Assumes a 100 MHz pclk and an APB slave with 8-bit word-aligned addresses.
package pin_mux_pkg;

    // Register byte addresses, one aligned word each
    localparam logic [7:0] ADDR_INT_EDGE   = 8'h00;
    localparam logic [7:0] ADDR_COM_DECODE = 8'h04;
    localparam logic [7:0] ADDR_HOST_DMA   = 8'h08;
    localparam logic [7:0] ADDR_SYS_CONFIG = 8'h0C;
    localparam logic [7:0] ADDR_CLOCK_CTRL = 8'h10;
    localparam logic [7:0] ADDR_PORT_C_SEL = 8'h14;
    localparam logic [7:0] ADDR_STATUS     = 8'h18;

    // Field positions
    localparam int MEM_STROBE_BIT = 3;   // interrupt edge/pin register
    localparam int DAISY_OUT_BIT  = 2;   // interrupt edge/pin register
    localparam int COM_PIN_BIT    = 0;   // com-port decode register
    localparam int COM_DEC_EN_BIT = 1;   // com-port decode register
    localparam int BUS_SWAP_BIT   = 2;   // host DMA enable register
    localparam int SERIAL_TX_BIT  = 1;   // system configuration register
    localparam int CLK_DIV1_BIT   = 0;   // clock control register
    localparam int CLK_MULT_BIT   = 1;   // clock control register
    localparam int PORT_C_INT_BIT = 0;   // port C select register

    // Values after reset
    localparam logic [7:0] INT_EDGE_RST   = 8'h00;
    localparam logic [7:0] COM_DECODE_RST = 8'h01;
    localparam logic [7:0] HOST_DMA_RST   = 8'h00;
    localparam logic [7:0] SYS_CONFIG_RST = 8'h00;
    localparam logic [7:0] CLOCK_CTRL_RST = 8'h00;
    localparam logic [7:0] PORT_C_SEL_RST = 8'h00;

    // Clock generator timing
    localparam int PCLK_PERIOD_NS   = 10;
    localparam int EXT_CLK_PERIOD_NS = 40;
    localparam int EXT_CLK_CYCLES   = EXT_CLK_PERIOD_NS / PCLK_PERIOD_NS;
    localparam int CNT_W            = 4;
    localparam logic [CNT_W-1:0] PERIOD_DIV2 = CNT_W'(2 * EXT_CLK_CYCLES);
    localparam logic [CNT_W-1:0] PERIOD_DIV1 = CNT_W'(EXT_CLK_CYCLES);
    localparam logic [CNT_W-1:0] PERIOD_MULT = CNT_W'(EXT_CLK_CYCLES / 2);

    // Clock rate modes
    typedef enum logic [1:0] {
        RATE_DIV2,
        RATE_DIV1,
        RATE_MULT
    } rate_t;

    // Address match, used by every register decode
    function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] reg_addr);
        return addr == reg_addr;
    endfunction
endpackage

// >>> hdl/pin_ctrl_if.sv
// Carrier between the register slave and the pin selector.
// Assumes both ends run on the same pclk.
`timescale 1ns/1ps
interface pin_ctrl_if;
    logic       mem_strobe_sel;
    logic       daisy_out_sel;
    logic       com_pin_sel;
    logic       com_decode_en;
    logic       bus_swap_sel;
    logic       serial_tx_sel;
    logic       int_as_port_sel;
    logic       clk_div1;
    logic       clk_mult;
    logic [7:0] status;

    modport regs (output mem_strobe_sel, daisy_out_sel, com_pin_sel, com_decode_en,
                  bus_swap_sel, serial_tx_sel, int_as_port_sel, clk_div1, clk_mult,
                  input status);
    modport mux  (input mem_strobe_sel, daisy_out_sel, com_pin_sel, com_decode_en,
                  bus_swap_sel, serial_tx_sel, int_as_port_sel, clk_div1, clk_mult,
                  output status);
endinterface

// >>> hdl/sys_clk_gen.sv
// System clock generator as an enable pulse plus a clock-level output.
// Assumes pclk stands for the crystal; rates above pclk cannot exist.
`timescale 1ns/1ps
module sys_clk_gen
    import pin_mux_pkg::*;
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic div1,
    input  wire logic mult,
    output logic      tick_r,
    output logic      phi_r
);

    rate_t            rate;
    logic [CNT_W-1:0] period;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic             wrap;

    // Multiplier wins over the divide choice
    assign rate    = mult ? RATE_MULT : (div1 ? RATE_DIV1 : RATE_DIV2);
    assign period  = (rate == RATE_MULT) ? PERIOD_MULT :
                     (rate == RATE_DIV1) ? PERIOD_DIV1 : PERIOD_DIV2;
    // A shortened period mid-count wraps at once rather than overrunning
    assign wrap    = cnt_r >= period - CNT_W'(1);
    assign cnt_nxt = wrap ? '0 : cnt_r + CNT_W'(1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r  <= '0;
            tick_r <= 1'b0;
            phi_r  <= 1'b0;
        end else begin
            cnt_r  <= cnt_nxt;
            tick_r <= wrap;
            phi_r  <= cnt_nxt < (period >> 1);
        end
    end

endmodule

// >>> hdl/pin_mux_regs.sv
// APB slave holding the pin function control bits.
// Assumes APB3 signalling; answers with zero wait states.
`timescale 1ns/1ps
module pin_mux_regs
    import pin_mux_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    pin_ctrl_if.regs         ctrl
);

    logic [7:0] int_edge_r, com_decode_r, host_dma_r, sys_config_r, clock_ctrl_r, port_c_sel_r;
    logic       hit_int, hit_com, hit_dma, hit_sys, hit_clk, hit_pc, hit_st, mapped;
    logic       setup, wr_en;
    logic [7:0] rd_mux;

    // Address decode
    assign hit_int = addr_hit(paddr, ADDR_INT_EDGE);
    assign hit_com = addr_hit(paddr, ADDR_COM_DECODE);
    assign hit_dma = addr_hit(paddr, ADDR_HOST_DMA);
    assign hit_sys = addr_hit(paddr, ADDR_SYS_CONFIG);
    assign hit_clk = addr_hit(paddr, ADDR_CLOCK_CTRL);
    assign hit_pc  = addr_hit(paddr, ADDR_PORT_C_SEL);
    assign hit_st  = addr_hit(paddr, ADDR_STATUS);
    assign mapped  = hit_int | hit_com | hit_dma | hit_sys | hit_clk | hit_pc | hit_st;
    assign setup   = psel & ~penable;
    assign wr_en   = psel & penable & pready & pwrite & ~pslverr;
    assign rd_mux  = hit_int ? int_edge_r : hit_com ? com_decode_r : hit_dma ? host_dma_r :
                     hit_sys ? sys_config_r : hit_clk ? clock_ctrl_r :
                     hit_pc ? port_c_sel_r : hit_st ? ctrl.status : 8'h00;

    // Answer is prepared in setup so pready is high in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= setup;
            pslverr <= setup & ~mapped;
            prdata  <= setup & ~pwrite ? {24'h000000, rd_mux} : 32'h00000000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_edge_r   <= INT_EDGE_RST;
            com_decode_r <= COM_DECODE_RST;
            host_dma_r   <= HOST_DMA_RST;
            sys_config_r <= SYS_CONFIG_RST;
            clock_ctrl_r <= CLOCK_CTRL_RST;
            port_c_sel_r <= PORT_C_SEL_RST;
        end else if (wr_en) begin
            if (hit_int) int_edge_r   <= pwdata[7:0];
            if (hit_com) com_decode_r <= pwdata[7:0];
            if (hit_dma) host_dma_r   <= pwdata[7:0];
            if (hit_sys) sys_config_r <= pwdata[7:0];
            if (hit_clk) clock_ctrl_r <= pwdata[7:0];
            if (hit_pc)  port_c_sel_r <= pwdata[7:0];
        end
    end

    // Control bits handed to the selector
    assign ctrl.mem_strobe_sel  = int_edge_r[MEM_STROBE_BIT];
    assign ctrl.daisy_out_sel   = int_edge_r[DAISY_OUT_BIT];
    assign ctrl.com_pin_sel     = com_decode_r[COM_PIN_BIT];
    assign ctrl.com_decode_en   = com_decode_r[COM_DEC_EN_BIT];
    assign ctrl.bus_swap_sel    = host_dma_r[BUS_SWAP_BIT];
    assign ctrl.serial_tx_sel   = sys_config_r[SERIAL_TX_BIT];
    assign ctrl.int_as_port_sel = port_c_sel_r[PORT_C_INT_BIT];
    assign ctrl.clk_div1        = clock_ctrl_r[CLK_DIV1_BIT];
    assign ctrl.clk_mult        = clock_ctrl_r[CLK_MULT_BIT];

endmodule

// >>> sim/pin_mux_properties.sv
// Checker for the shared pin selector, bound to the top module.
// Assumes one pclk domain with an asynchronous active-low presetn.
`timescale 1ns/1ps
module pin_mux_properties
    import pin_mux_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic [7:0]  paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        memory_read_strobe_n,
    input wire logic        memory_request_n,
    input wire logic        io_select_one_n,
    input wire logic        daisy_chain_enable_out,
    input wire logic        host_drive_disable_n,
    input wire logic        serial0_transmit_out,
    input wire logic        pin_mem_ctl_out,
    input wire logic        pin_sel1_out,
    input wire logic        pin_drv_dis_out,
    input wire logic        host_addr_line_7,
    input wire logic        host_addr_line_3,
    input wire logic        host_addr_line_4,
    input wire logic        daisy_chain_enable_in,
    input wire logic        pin_a3_oe,
    input wire logic        host_dma_ack_1_n,
    input wire logic        bus_hold_request_in_n,
    input wire logic        pin_dma_ack_in,
    input wire logic        interrupt_in_1_n,
    input wire logic        port_c_line_6,
    input wire logic        pin_irq1_in,
    input wire logic        com_decode_enable,
    input wire logic        sys_clk_tick
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic [1:0] age_r;
    logic       com_wr;
    // Mux relations only hold once the first registered values have landed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            age_r <= 2'h0;
        end else if (!age_r[1]) begin
            age_r <= age_r + 2'h1;
        end
    end
    // Committed write that sets the decode enable bit
    assign com_wr = psel && penable && pready && pwrite && paddr == ADDR_COM_DECODE
                    && pwdata[COM_DEC_EN_BIT];

    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_tick;
        sys_clk_tick;
    endsequence

    AST_APB_READY: assert property (s_setup |=> pready)
        else $error("pready missing after setup");
    AST_ERR_READY: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    AST_TICK_PULSE: assert property (s_tick |=> !sys_clk_tick)
        else $error("tick wider than one cycle");
    AST_TICK_PERIOD: assert property (s_tick |-> ##[2:16] s_tick)
        else $error("tick period out of range");
    AST_MEM_CTL: assert property (age_r[1] |-> pin_mem_ctl_out == $past(memory_read_strobe_n)
        || pin_mem_ctl_out == $past(memory_request_n))
        else $error("memory control pin from no source");
    AST_SEL1: assert property (age_r[1] |-> pin_sel1_out == $past(io_select_one_n)
        || pin_sel1_out == $past(daisy_chain_enable_out))
        else $error("select pin from no source");
    AST_ADDR_MODE: assert property (!daisy_chain_enable_in |->
        {host_addr_line_7, host_addr_line_3, host_addr_line_4} == 3'h0)
        else $error("address lines live outside address mode");
    AST_A3_HIZ: assert property ((!age_r[1] || host_addr_line_3 || host_addr_line_7) |-> !pin_a3_oe)
        else $error("address pin driven");
    AST_DMA_SWAP: assert property (
        age_r[1] |-> (host_dma_ack_1_n && bus_hold_request_in_n) == $past(pin_dma_ack_in))
        else $error("ack pin routed wrongly");
    AST_DRV_DIS: assert property (age_r[1] |-> pin_drv_dis_out == $past(host_drive_disable_n)
        || pin_drv_dis_out == $past(serial0_transmit_out))
        else $error("drive-disable pin from no source");
    AST_IRQ_LOW: assert property (
        age_r[1] && !interrupt_in_1_n |-> !port_c_line_6 && !$past(pin_irq1_in))
        else $error("interrupt low without pin low");
    AST_PORT_C6: assert property (port_c_line_6 |-> interrupt_in_1_n)
        else $error("pin seen by both functions");
    AST_DEC_EN: assert property ($rose(com_decode_enable) |-> $past(com_wr, 2))
        else $error("decode enabled without a write");
endmodule

bind pin_mux_top pin_mux_properties chk_u (.*);

// >>> sim/pin_board_model.sv
// Board and host-bus model facing the shared package pins.
// Assumes the bench sets the wanted board levels in brd_lvl.
`timescale 1ns/1ps
module pin_board_model (
    input  wire logic       pclk,
    input  wire logic [6:0] brd_lvl,
    input  wire logic       pin_c2_out,
    input  wire logic       pin_c2_oe,
    input  wire logic       pin_a3_out,
    input  wire logic       pin_a3_oe,
    output logic            pin_c2_in,
    output logic            pin_a7_in,
    output logic            pin_a3_in,
    output logic            pin_a4_in,
    output logic            pin_dma_ack_in,
    output logic            pin_irq1_in,
    output logic            pin_irq2_in
);
    logic [6:0] lvl_r = 7'h7F;
    // Board levels move just after an edge, like any synchronous source
    always_ff @(posedge pclk) begin
        lvl_r <= brd_lvl;
    end
    // host drives address
    // Two-way lines: the device wins while its enable is high
    assign pin_a3_in = pin_a3_oe ? pin_a3_out : lvl_r[0];
    assign pin_c2_in = pin_c2_oe ? pin_c2_out : lvl_r[1];
    assign {pin_irq2_in, pin_irq1_in, pin_dma_ack_in, pin_a4_in, pin_a7_in} = lvl_r[6:2];
endmodule

// >>> sim/tb.sv
// Self-checking bench for the shared pin selector.
// Assumes the board model drives every pad input.
`timescale 1ns/1ps
module tb
    import pin_mux_pkg::*;
();
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic port_c2_out, port_c2_oe, memory_write_strobe_n, memory_read_strobe_n,
        memory_request_n, io_select_one_n, daisy_chain_enable_out, refresh_cycle_n,
        host_dma_request_1, bus_grant_out_n, host_drive_disable_n, serial0_transmit_out;
    logic port_c_line_2, host_addr_line_7, daisy_chain_enable_in, host_addr_line_3,
        host_addr_line_4, bus_stall_in_n, host_dma_ack_1_n, bus_hold_request_in_n,
        interrupt_in_1_n, interrupt_in_2_n, port_c_line_6, port_c_line_7,
        com_decode_enable, sys_clk_tick;
    logic pin_c2_in, pin_c2_out, pin_c2_oe, pin_mem_ctl_out, pin_sel1_out, pin_a7_in,
        pin_a3_in, pin_a3_out, pin_a3_oe, pin_a4_in, pin_dma_req_out, pin_dma_req_oe,
        pin_dma_ack_in, pin_drv_dis_out, pin_irq1_in, pin_irq2_in, pin_clk_out;
    logic [11:0] core_v, c;
    logic [6:0]  brd_lvl, b;
    int          failures, compares;

    pin_mux_top dut_u (.*);
    pin_board_model board_u (.*);
    // Core-side sources from one word, so patterns stay readable
    assign {serial0_transmit_out, host_drive_disable_n, bus_grant_out_n, host_dma_request_1,
            refresh_cycle_n, daisy_chain_enable_out, io_select_one_n, memory_request_n,
            memory_read_strobe_n, memory_write_strobe_n, port_c2_oe, port_c2_out} = core_v;

    task automatic give_verdict();
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_pin(input logic got, input logic exp);
        chk(32'(got), 32'(exp));
    endtask
    // One APB transfer; entered right after a rising edge, leaves one idle edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n == 16) begin
            failures++;
            give_verdict();
        end
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic eexp);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0, q, e);
        chk(q, {24'h0, exp});
        chk_pin(e, eexp);
    endtask
    task automatic cfg(input logic s);
        wr(ADDR_INT_EDGE, s ? 32'h0C : 32'h0);
        wr(ADDR_COM_DECODE, s ? 32'h2 : 32'h1);
        wr(ADDR_HOST_DMA, s ? 32'h4 : 32'h0);
        wr(ADDR_SYS_CONFIG, s ? 32'h2 : 32'h0);
        wr(ADDR_PORT_C_SEL, s ? 32'h1 : 32'h0);
        repeat (3) @(posedge pclk);
    endtask
    // Cycles between two ticks once the rate has settled
    task automatic tick_gap(input int exp);
        int n;
        repeat (20) @(posedge pclk);
        for (n = 0; n < 40 && sys_clk_tick !== 1'b1; n++) @(posedge pclk);
        @(posedge pclk);
        for (n = 1; n < 40 && sys_clk_tick !== 1'b1; n++) @(posedge pclk);
        if (n == 40) begin
            failures++;
            give_verdict();
        end
        chk(32'({n[7:0], pin_clk_out}), 32'({exp[7:0], 1'b1}));
    endtask

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // Reset values, both pin functions twice, clock rates, reset again
    initial begin
        failures = 0;
        compares = 0;
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        core_v = 12'h52E;
        brd_lvl = 7'h55;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk_pin(pin_a3_oe, 1'b0);
        rd(ADDR_INT_EDGE, INT_EDGE_RST, 1'b0);
        rd(ADDR_COM_DECODE, COM_DECODE_RST, 1'b0);
        rd(ADDR_HOST_DMA, HOST_DMA_RST, 1'b0);
        rd(ADDR_SYS_CONFIG, SYS_CONFIG_RST, 1'b0);
        rd(ADDR_PORT_C_SEL, PORT_C_SEL_RST, 1'b0);
        chk_pin(com_decode_enable, 1'b0);
        wr(8'h1C, 32'hFF);
        rd(8'h1C, 8'h00, 1'b1);
        wr(ADDR_HOST_DMA, 32'hFFFF_FF04);
        rd(ADDR_HOST_DMA, 8'h04, 1'b0);
        for (int i = 0; i < 2; i++) begin
            c = (i == 0) ? 12'h52E : ~12'h52E;
            b = (i == 0) ? 7'h55 : 7'h2A;
            core_v <= c;
            brd_lvl <= b;
            cfg(1'b0);
            chk(32'({pin_c2_out, pin_c2_oe, pin_mem_ctl_out}), 32'({c[0], c[1], c[4]}));
            chk_pin(port_c_line_2, c[1] ? c[0] : b[1]);
            chk_pin(pin_sel1_out, c[5]);
            chk(32'({pin_a3_oe, host_addr_line_7, host_addr_line_3, host_addr_line_4,
                daisy_chain_enable_in, bus_stall_in_n}), 32'({1'b0, b[2], b[0], b[3], 2'h3}));
            chk(32'({pin_dma_req_oe, pin_dma_req_out, host_dma_ack_1_n, bus_hold_request_in_n}),
                32'({1'b1, c[8], b[4], 1'b1}));
            chk_pin(pin_drv_dis_out, c[10]);
            chk(32'({interrupt_in_1_n, port_c_line_6, interrupt_in_2_n, port_c_line_7}),
                32'({b[5], 1'b0, b[6], 1'b0}));
            cfg(1'b1);
            chk(32'({pin_c2_out, pin_c2_oe, pin_mem_ctl_out, port_c_line_2}),
                32'({c[2], 1'b1, c[3], c[2]}));
            chk_pin(pin_sel1_out, c[6]);
            chk(32'({pin_a3_oe, pin_a3_out, host_addr_line_7, host_addr_line_3, host_addr_line_4,
                daisy_chain_enable_in, bus_stall_in_n}), 32'({1'b1, c[7], 3'h0, b[2], b[3]}));
            chk_pin(com_decode_enable, 1'b1);
            chk(32'({pin_dma_req_out, host_dma_ack_1_n, bus_hold_request_in_n}),
                32'({c[9], 1'b1, b[4]}));
            chk_pin(pin_drv_dis_out, c[11]);
            chk(32'({interrupt_in_1_n, port_c_line_6, interrupt_in_2_n, port_c_line_7}),
                32'({1'b1, b[5], 1'b1, b[6]}));
        end
        for (int m = 0; m < 4; m++) begin
            wr(ADDR_CLOCK_CTRL, 32'(m));
            tick_gap(m == 0 ? 8 : (m == 1 ? 4 : 2));
        end
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(ADDR_COM_DECODE, COM_DECODE_RST, 1'b0);
        rd(ADDR_CLOCK_CTRL, CLOCK_CTRL_RST, 1'b0);
        tick_gap(8);
        give_verdict();
    end
endmodule
